//--- cad_pkg.sv
// constants and types for the core address decoder and environment selector
//----------------------------------------------------------------------------
// Behaviour
// - development environment allowed only in the large 176-pin package
// - development environment disables on-chip flash; base memory goes off-chip
// - development environment gives groups H,J,K,L,M to memory, status, reset, break
// - access timing identical in all environments; no environment-dependent stalls
// - strap a high, strap b and tristate floating selects development environment
// - development environment holds reset while flash protect bit reads zero
// - programming environment holds core in reset, pins go to flash port
// - both environment straps high select programming environment
// - all memories and I/O decoded in one 2 Mbyte core space
// - first 64 Kbytes flagged as the fast data zone
// - 00_0000..00_DFFF decodes as base memory, target depends on environment
// - 00_F900..00_F90A decodes as shared-BIOS and security registers
// - 10_0000..1F_FFFF decodes as expansion memory only in 176-pin package
// - ROM variant: expansion aliased below and above 01_0000; limited to 1 Mbyte only in the small package
//----------------------------------------------------------------------------
package cad_pkg;

  localparam int CAD_AW = 21;

  // region bounds
  localparam logic [20:0] CAD_BASE_LO  = 21'h000000;
  localparam logic [20:0] CAD_BASE_HI  = 21'h00DFFF;
  localparam logic [20:0] CAD_ROMB_HI  = 21'h000FFF;
  localparam logic [20:0] CAD_RAM4_LO  = 21'h00E800;
  localparam logic [20:0] CAD_RAM2_LO  = 21'h00F000;
  localparam logic [20:0] CAD_RAM_HI   = 21'h00F7FF;
  localparam logic [20:0] CAD_FCTL_LO  = 21'h00F880;
  localparam logic [20:0] CAD_FCTL_HI  = 21'h00F8FF;
  localparam logic [20:0] CAD_SEC_LO   = 21'h00F900;
  localparam logic [20:0] CAD_SEC_HI   = 21'h00F90A;
  localparam logic [20:0] CAD_BIU_LO   = 21'h00F980;
  localparam logic [20:0] CAD_BIU_HI   = 21'h00F98F;
  localparam logic [20:0] CAD_DMA_LO   = 21'h00FA00;
  localparam logic [20:0] CAD_DMA_HI   = 21'h00FA7F;
  localparam logic [20:0] CAD_IOX_LO   = 21'h00FB00;
  localparam logic [20:0] CAD_IOX_HI   = 21'h00FBFF;
  localparam logic [20:0] CAD_MOD_LO   = 21'h00FC00;
  localparam logic [20:0] CAD_MOD_HI   = 21'h00FFFF;
  localparam logic [20:0] CAD_BASE2_LO = 21'h010000;
  localparam logic [20:0] CAD_BASE2_HI = 21'h01FFFF;
  localparam logic [20:0] CAD_DEVB_HI  = 21'h0FFFFF;
  localparam logic [20:0] CAD_EXP_LO   = 21'h100000;
  localparam logic [20:0] CAD_EXP_HI   = 21'h1FFFFF;
  localparam logic [20:0] CAD_FAST_HI  = 21'h00FFFF;

  // region select bit positions
  localparam int CAD_NSEL     = 10;
  localparam int CAD_SEL_BASE = 0;
  localparam int CAD_SEL_RAM  = 1;
  localparam int CAD_SEL_FCTL = 2;
  localparam int CAD_SEL_SEC  = 3;
  localparam int CAD_SEL_BIU  = 4;
  localparam int CAD_SEL_DMA  = 5;
  localparam int CAD_SEL_IOX  = 6;
  localparam int CAD_SEL_MOD  = 7;
  localparam int CAD_SEL_EXP  = 8;
  localparam int CAD_SEL_RSV  = 9;

  // part variants
  typedef enum logic [1:0] {CAD_VAR_E, CAD_VAR_S, CAD_VAR_L} cad_variant_t;

  // operating environments
  typedef enum logic [1:0] {
    internal_rom_env, onboard_debug_env, development_env, programming_env
  } cad_env_t;

  // strap latch sequencing
  typedef enum logic [1:0] {CAD_ST_STRAP, CAD_ST_RUN} cad_state_t;

  localparam logic [1:0] CAD_PINMUX_GPIO = 2'h0;
  localparam logic [1:0] CAD_PINMUX_DEV  = 2'h1;
  localparam logic [1:0] CAD_PINMUX_PROGRAMMING_ENV = 2'h2;

endpackage

//--- cad_range.sv
// inclusive address window compare
`timescale 1ns/1ps
module cad_range
  import cad_pkg::*;
#(
  parameter logic [20:0] LO = 21'h000000,
  parameter logic [20:0] HI = 21'h000000
)(
  input  wire logic [20:0] addr,
  output logic             hit
);
  // both bounds inclusive
  assign hit = (addr >= LO) && (addr <= HI);
endmodule

//--- cad_decode.sv
// core address decoder and operating environment selector
`timescale 1ns/1ps
module cad_decode
  import cad_pkg::*;
#(
  parameter cad_variant_t VARIANT  = CAD_VAR_E,
  parameter logic         PKG_176  = 1'b1
)(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                env_strap_a,
  input  wire logic                env_strap_b,
  input  wire logic                tristate_strap,
  input  wire logic                flash_protect_bit,
  input  wire logic [20:0]         core_addr,
  input  wire logic                core_req,
  output logic [CAD_NSEL-1:0]      region_sel,
  output logic                     onchip_flash_en,
  output logic                     offchip_base_sel,
  output logic                     fast_zone,
  output logic                     core_reset_hold,
  output logic [1:0]               pin_mux_mode,
  output logic [1:0]               env_code,
  output logic                     dev_env_rejected
);

  //--------------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_t;
    logic [1:0] sync_p;
    logic [1:0] settle;
    cad_state_t st;
    cad_env_t   env;
    logic       rejected;
    logic       hold;
    logic [1:0] mux;
  } cad_regs_t;

  cad_regs_t state_ff;
  cad_regs_t nxt_state;

  //--------------------------------------------------------------------------
  // address window hits
  //--------------------------------------------------------------------------
  logic [20:0] a;
  logic h_base, h_romb, h_ram4, h_ram2, h_fctl, h_sec, h_biu, h_dma, h_iox, h_mod;
  logic h_base2, h_devb, h_exp;

  assign a = core_addr;

  cad_range #(.LO(CAD_BASE_LO),  .HI(CAD_BASE_HI))  u_base  (.addr(a), .hit(h_base));
  cad_range #(.LO(CAD_BASE_LO),  .HI(CAD_ROMB_HI))  u_romb  (.addr(a), .hit(h_romb));
  cad_range #(.LO(CAD_RAM4_LO),  .HI(CAD_RAM_HI))   u_ram4  (.addr(a), .hit(h_ram4));
  cad_range #(.LO(CAD_RAM2_LO),  .HI(CAD_RAM_HI))   u_ram2  (.addr(a), .hit(h_ram2));
  cad_range #(.LO(CAD_FCTL_LO),  .HI(CAD_FCTL_HI))  u_fctl  (.addr(a), .hit(h_fctl));
  cad_range #(.LO(CAD_SEC_LO),   .HI(CAD_SEC_HI))   u_sec   (.addr(a), .hit(h_sec));
  cad_range #(.LO(CAD_BIU_LO),   .HI(CAD_BIU_HI))   u_biu   (.addr(a), .hit(h_biu));
  cad_range #(.LO(CAD_DMA_LO),   .HI(CAD_DMA_HI))   u_dma   (.addr(a), .hit(h_dma));
  cad_range #(.LO(CAD_IOX_LO),   .HI(CAD_IOX_HI))   u_iox   (.addr(a), .hit(h_iox));
  cad_range #(.LO(CAD_MOD_LO),   .HI(CAD_MOD_HI))   u_mod   (.addr(a), .hit(h_mod));
  cad_range #(.LO(CAD_BASE2_LO), .HI(CAD_BASE2_HI)) u_base2 (.addr(a), .hit(h_base2));
  cad_range #(.LO(CAD_BASE2_LO), .HI(CAD_DEVB_HI))  u_devb  (.addr(a), .hit(h_devb));
  cad_range #(.LO(CAD_EXP_LO),   .HI(CAD_EXP_HI))   u_exp   (.addr(a), .hit(h_exp));

  //--------------------------------------------------------------------------
  // strap capture and reset holding
  //--------------------------------------------------------------------------
  logic     is_dev;
  logic     is_programming_env;
  cad_env_t strap_env;

  assign is_dev  = (state_ff.env == development_env);
  assign is_programming_env = (state_ff.env == programming_env);

  // floating straps read low through on-chip pull-downs
  always_comb
  begin
    if (state_ff.sync_a[1] && state_ff.sync_b[1])
      strap_env = programming_env;
    else if (state_ff.sync_a[1] && !state_ff.sync_t[1])
      strap_env = development_env;
    else if (state_ff.sync_b[1])
      strap_env = onboard_debug_env;
    else
      strap_env = internal_rom_env;
  end

  // straps are sampled once, after the synchronisers settle, then frozen
  always_comb
  begin
    nxt_state        = state_ff;
    nxt_state.sync_a = {state_ff.sync_a[0], env_strap_a};
    nxt_state.sync_b = {state_ff.sync_b[0], env_strap_b};
    nxt_state.sync_t = {state_ff.sync_t[0], tristate_strap};
    nxt_state.sync_p = {state_ff.sync_p[0], flash_protect_bit};
    nxt_state.settle = {state_ff.settle[0], 1'b1};
    unique case (state_ff.st)
      CAD_ST_STRAP:
      begin
        // syncs leave reset at zero; latching before they fill would lose every strap
        if (state_ff.settle[1])
        begin
          nxt_state.st = CAD_ST_RUN;
          if (strap_env == development_env && !PKG_176)
          begin
            // small package cannot host the development board pins
            nxt_state.env      = internal_rom_env;
            nxt_state.rejected = 1'b1;
          end
          else
          begin
            nxt_state.env = strap_env;
          end
        end
      end
      CAD_ST_RUN:
      begin
        nxt_state.st = CAD_ST_RUN;
      end
    endcase
    // hold reset: programming forever, development while protect bit clear
    nxt_state.hold = (state_ff.st == CAD_ST_STRAP) ||
                     (nxt_state.env == programming_env) ||
                     (nxt_state.env == development_env && !state_ff.sync_p[1]);
    if (nxt_state.env == development_env)
      nxt_state.mux = CAD_PINMUX_DEV;
    else if (nxt_state.env == programming_env)
      nxt_state.mux = CAD_PINMUX_PROGRAMMING_ENV;
    else
      nxt_state.mux = CAD_PINMUX_GPIO;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff.sync_a   <= 2'h0;
      state_ff.sync_b   <= 2'h0;
      state_ff.sync_t   <= 2'h0;
      state_ff.sync_p   <= 2'h0;
      state_ff.settle   <= 2'h0;
      state_ff.st       <= CAD_ST_STRAP;
      state_ff.env      <= internal_rom_env;
      state_ff.rejected <= 1'b0;
      state_ff.hold     <= 1'b1;
      state_ff.mux      <= CAD_PINMUX_GPIO;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  //--------------------------------------------------------------------------
  // region decode: purely combinational, so no environment adds latency
  //--------------------------------------------------------------------------
  logic [CAD_NSEL-1:0] sel;
  logic                base_hit;
  logic                exp_hit;
  logic                ram_hit;

  always_comb
  begin
    ram_hit  = (VARIANT == CAD_VAR_S) ? h_ram4 : h_ram2;
    if (VARIANT == CAD_VAR_L)
    begin
      // rom part: tiny base, expansion aliased below and above 01_0000
      base_hit = h_romb;
      exp_hit  = (h_base && !h_romb) || h_devb || (h_exp && PKG_176);
    end
    else
    begin
      base_hit = h_base ||
                 (VARIANT == CAD_VAR_S && h_base2) ||
                 (is_dev && h_devb);
      exp_hit  = h_exp && PKG_176;
    end
    sel                = '0;
    // priority chain guarantees a single select
    if (base_hit)      sel[CAD_SEL_BASE] = 1'b1;
    else if (exp_hit)  sel[CAD_SEL_EXP]  = 1'b1;
    else if (ram_hit)  sel[CAD_SEL_RAM]  = 1'b1;
    else if (h_fctl)   sel[CAD_SEL_FCTL] = 1'b1;
    else if (h_sec)    sel[CAD_SEL_SEC]  = 1'b1;
    else if (h_biu)    sel[CAD_SEL_BIU]  = 1'b1;
    else if (h_dma)    sel[CAD_SEL_DMA]  = 1'b1;
    else if (h_iox)    sel[CAD_SEL_IOX]  = 1'b1;
    else if (h_mod)    sel[CAD_SEL_MOD]  = 1'b1;
    else               sel[CAD_SEL_RSV]  = 1'b1;
  end

  // 21 address bits span exactly the 2 Mbyte space
  assign region_sel       = (core_req && !state_ff.hold) ? sel : '0;
  assign onchip_flash_en  = !is_dev;
  assign offchip_base_sel = region_sel[CAD_SEL_BASE] && is_dev;
  assign fast_zone        = core_req && (a <= CAD_FAST_HI);
  assign core_reset_hold  = state_ff.hold;
  assign pin_mux_mode     = state_ff.mux;
  assign env_code         = state_ff.env;
  assign dev_env_rejected = state_ff.rejected;

  //--------------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------------
  sequence s_strapped;
    state_ff.st == CAD_ST_RUN;
  endsequence

  a_one_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $onehot0(region_sel)) else $error("more than one region select");
  a_dev_pkg: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !PKG_176 |-> env_code != development_env) else $error("dev env in small package");
  a_dev_flash: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_dev |-> !onchip_flash_en) else $error("flash on in dev env");
  a_programming_env_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_programming_env |=> core_reset_hold && pin_mux_mode == CAD_PINMUX_PROGRAMMING_ENV)
    else $error("programming_env env released core");
  a_protect_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_strapped and is_dev && !state_ff.sync_p[1]) |=> core_reset_hold)
    else $error("dev env ran without protect bit");
  a_sec_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (core_req && !core_reset_hold && a >= CAD_SEC_LO && a <= CAD_SEC_HI)
    |-> region_sel[CAD_SEL_SEC]) else $error("security block not selected");
  a_exp_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (core_req && !core_reset_hold && a >= CAD_EXP_LO)
    |-> region_sel[CAD_SEL_EXP] == PKG_176) else $error("expansion decode wrong");
  a_base_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (core_req && !core_reset_hold && a <= CAD_BASE_HI && VARIANT != CAD_VAR_L)
    |-> region_sel[CAD_SEL_BASE]) else $error("base memory not selected");
  a_strap_programming_env: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff.st == CAD_ST_STRAP && state_ff.settle[1] && state_ff.sync_a[1] && state_ff.sync_b[1])
    |=> is_programming_env) else $error("programming_env straps not honoured");
  a_strap_dev: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff.st == CAD_ST_STRAP && state_ff.settle[1] && state_ff.sync_a[1] && !state_ff.sync_b[1]
     && !state_ff.sync_t[1] && PKG_176) |=> is_dev) else $error("dev straps ignored");
  a_env_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_strapped |=> $stable(env_code)) else $error("environment changed after strap");

endmodule

//--- cad_core_model.sv
// core bus master and off-chip base memory model for the address decoder bench
`timescale 1ns/1ps
module cad_core_model
  import cad_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        offchip_base_sel,
  output logic [20:0]      core_addr,
  output logic             core_req,
  output logic [7:0]       base_rdata
);
  logic [7:0] last_q;

  //--------------------------------------------------------------------------
  // off-chip base memory
  //--------------------------------------------------------------------------
  // a released data bus shows the inverse of its last byte, so stale data never matches
  always_comb
  begin
    base_rdata = offchip_base_sel ? (core_addr[7:0] ^ 8'hA5) : ~last_q;
  end

  initial
  begin
    core_addr = 21'h000000;
    core_req  = 1'b0;
    last_q    = 8'h00;
  end

  always @(posedge ref_clk)
  begin
    last_q <= base_rdata;
  end

  //--------------------------------------------------------------------------
  // core bus master
  //--------------------------------------------------------------------------
  // request changes just after an edge; decode is looked at mid-cycle
  task automatic access(input logic [20:0] addr, input logic req);
    @(posedge ref_clk);
    core_addr <= addr;
    core_req  <= req;
    @(negedge ref_clk);
  endtask
endmodule

//--- testbench.sv
// self-checking testbench for the core address decoder and environment selector
`timescale 1ns/1ps
module testbench;
  import cad_pkg::*;
  logic        ref_clk, reset_n, env_strap_a, env_strap_b, tristate_strap;
  logic        flash_protect_bit, core_req, onchip_flash_en, offchip_base_sel;
  logic        fast_zone, core_reset_hold, dev_env_rejected, rej_s, hold_s;
  logic [20:0] core_addr;
  logic [9:0]  region_sel, sel_s;
  logic [7:0]  base_rdata;
  logic [1:0]  pin_mux_mode, env_code, env_s;
  int          error_cnt, compares;
  // decode table: address, expected select on the large E part, on the small L part
  // reserved entries only probe the select; no data is ever taken from them
  localparam logic [20:0] TA [17] = '{21'h000000, 21'h000FFF, 21'h001000, 21'h00DFFF,
    21'h00E000, 21'h00F000, 21'h00F7FF, 21'h00F880, 21'h00F900, 21'h00F90A, 21'h00F90B,
    21'h00F980, 21'h00FA7F, 21'h00FB00, 21'h00FFFF, 21'h010000, 21'h100000};
  localparam logic [9:0] TE [17] = '{10'h001, 10'h001, 10'h001, 10'h001, 10'h200,
    10'h002, 10'h002, 10'h004, 10'h008, 10'h008, 10'h200, 10'h010, 10'h020, 10'h040,
    10'h080, 10'h200, 10'h100};
  localparam logic [9:0] TL [17] = '{10'h001, 10'h001, 10'h100, 10'h100, 10'h200,
    10'h002, 10'h002, 10'h004, 10'h008, 10'h008, 10'h200, 10'h010, 10'h020, 10'h040,
    10'h080, 10'h100, 10'h200};

  cad_core_model cm_u (.ref_clk(ref_clk), .offchip_base_sel(offchip_base_sel),
    .core_addr(core_addr), .core_req(core_req), .base_rdata(base_rdata));

  cad_decode #(.VARIANT(CAD_VAR_E), .PKG_176(1'b1)) dut_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .env_strap_a(env_strap_a), .env_strap_b(env_strap_b),
    .tristate_strap(tristate_strap), .flash_protect_bit(flash_protect_bit),
    .core_addr(core_addr), .core_req(core_req), .region_sel(region_sel),
    .onchip_flash_en(onchip_flash_en), .offchip_base_sel(offchip_base_sel),
    .fast_zone(fast_zone), .core_reset_hold(core_reset_hold),
    .pin_mux_mode(pin_mux_mode), .env_code(env_code), .dev_env_rejected(dev_env_rejected));

  // small package part: development straps must be turned away here
  cad_decode #(.VARIANT(CAD_VAR_L), .PKG_176(1'b0)) dut_small_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .env_strap_a(env_strap_a), .env_strap_b(env_strap_b),
    .tristate_strap(tristate_strap), .flash_protect_bit(flash_protect_bit),
    .core_addr(core_addr), .core_req(core_req), .region_sel(sel_s),
    .onchip_flash_en(), .offchip_base_sel(), .fast_zone(), .core_reset_hold(hold_s),
    .pin_mux_mode(), .env_code(env_s), .dev_env_rejected(rej_s));

  //--------------------------------------------------------------------------
  // clock, checking and closing
  //--------------------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // straps stay put through reset and well past the latch edge
  task automatic restart(input logic a, input logic b, input logic t, input logic p);
    cm_u.access(21'h000000, 1'b0);
    @(posedge ref_clk);
    reset_n           <= 1'b0;
    env_strap_a       <= a;
    env_strap_b       <= b;
    tristate_strap    <= t;
    flash_protect_bit <= p;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic status(input logic [1:0] env, input logic hold, input logic [1:0] mux,
                        input logic fen);
    check(env_code, env);
    check(core_reset_hold, hold);
    check(pin_mux_mode, mux);
    check(onchip_flash_en, fen);
  endtask

  task automatic dec(input logic [20:0] a, input logic [9:0] exp);
    cm_u.access(a, 1'b1);
    check(region_sel, exp);
    check(fast_zone, a <= CAD_FAST_HI);
  endtask

  // bounded wait for the protect bit to reach the reset hold
  task automatic wait_hold(input logic v);
    int i;
    for (i = 0; i < 8 && core_reset_hold !== v; i++) @(negedge ref_clk);
    check(core_reset_hold, v);
  endtask

  //--------------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    compares  = 0;
    reset_n = 1'b0;
    {env_strap_a, env_strap_b, tristate_strap, flash_protect_bit} = 4'h0;
    restart(1'b0, 1'b0, 1'b0, 1'b1);
    status(internal_rom_env, 1'b0, CAD_PINMUX_GPIO, 1'b1);
    for (int i = 0; i < 17; i++)
    begin
      dec(TA[i], TE[i]);
      check(sel_s, TL[i]);
    end
    cm_u.access(21'h00F905, 1'b0);
    check(region_sel, 10'h000);
    restart(1'b0, 1'b1, 1'b0, 1'b1);
    status(onboard_debug_env, 1'b0, CAD_PINMUX_GPIO, 1'b1);
    restart(1'b1, 1'b0, 1'b1, 1'b1);
    status(internal_rom_env, 1'b0, CAD_PINMUX_GPIO, 1'b1);
    // development straps with the protect bit clear: core stays in reset
    restart(1'b1, 1'b0, 1'b0, 1'b0);
    status(development_env, 1'b1, CAD_PINMUX_DEV, 1'b0);
    check({env_s, rej_s, hold_s}, {internal_rom_env, 1'b1, 1'b0});
    check(dev_env_rejected, 1'b0);
    dec(21'h000000, 10'h000);
    @(posedge ref_clk);
    flash_protect_bit <= 1'b1;
    wait_hold(1'b0);
    dec(21'h000010, 10'h001);
    check({offchip_base_sel, base_rdata}, {1'b1, 8'hB5});
    dec(21'h0FFFFF, 10'h001);
    dec(21'h100000, 10'h100);
    check(offchip_base_sel, 1'b0);
    // board logic answers the displaced ports at the on-chip addresses
    dec(21'h00FB00, 10'h040);
    @(posedge ref_clk);
    flash_protect_bit <= 1'b0;
    wait_hold(1'b1);
    // programming straps, tristate both ways; later strap changes are ignored
    for (int t = 0; t < 2; t++)
    begin
      restart(1'b1, 1'b1, t[0], 1'b1);
      status(programming_env, 1'b1, CAD_PINMUX_PROGRAMMING_ENV, 1'b1);
      dec(21'h00F000, 10'h000);
    end
    @(posedge ref_clk);
    env_strap_a <= 1'b0;
    env_strap_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check(env_code, programming_env);
    complete_run();
  end

  // watchdog: the scenarios need under 150 cycles, the limit is 3000
  initial
  begin
    #(3000 * 25);
    error_cnt++;
    complete_run();
  end
endmodule
